//--- src/sfpl_datapath.sv
// Purpose: packed lane fixed-point datapath, one register stage
// Assumes: operands and controls come from decode on the core clock
// Notes: result and valid appear one clock after valid_i
`timescale 1ns/10ps
`default_nettype none
`include "sfpl_consts.svh"
module sfpl_datapath #(
  parameter int REG_W = `SFPL_REG_W // general register width
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic valid_i, // operation issued this cycle
  input wire sfpl_pkg::sfpl_op_t op_i,
  input wire sfpl_pkg::sfpl_fmt_t fmt_i,
  input wire sfpl_pkg::sfpl_mod_t mod_i,
  input wire logic uns_i, // unsigned variant
  input wire logic compact_i, // compact-encoding build
  input wire logic big_endian_i, // core endianness
  input wire logic [REG_W-1:0] src_a_i, // first source register
  input wire logic [REG_W-1:0] src_b_i, // second source register
  input wire logic [REG_W-1:0] acc_i, // accumulator lanes
  input wire logic [REG_W-1:0] mem_i, // load data, byte k at address k
  output logic valid_o,
  output logic [REG_W-1:0] result_o
);
  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int GW = `SFPL_GRP_W; // 32-bit group
  localparam int HW = `SFPL_HW_W; // halfword lane
  localparam int BW = `SFPL_BYTE_W; // byte lane
  localparam int N_BYTE = REG_W / BW;
  localparam int N_HALF = REG_W / HW;
  localparam int N_WORD = REG_W / GW;

  logic lane_uns; // signedness seen by lanes
  logic prec_rnd; // rounding for precision reduce
  logic prec_sat; // clamping for precision reduce
  logic [REG_W-1:0] byte_res; // byte quad lanes
  logic [REG_W-1:0] half_res; // halfword pair lanes
  logic [REG_W-1:0] word_res; // word lanes
  logic [REG_W-1:0] prec_res; // word to halfword pair
  logic [REG_W-1:0] load_be; // byte-reversed load data
  logic [REG_W-1:0] next_result;
  logic next_valid;

  // ****************************************************************
  // operand interpretation
  // ****************************************************************
  // fractional multiplies are signed whatever the opcode's u bit
  assign lane_uns = uns_i && (op_i != sfpl_pkg::sfpl_op_mulq) &&
                    (op_i != sfpl_pkg::sfpl_op_macq);
  assign prec_rnd = (mod_i == sfpl_pkg::sfpl_mod_round) ||
                    (mod_i == sfpl_pkg::round_and_clamp_modifier);
  assign prec_sat = (mod_i == sfpl_pkg::sfpl_mod_clamp) ||
                    (mod_i == sfpl_pkg::round_and_clamp_modifier);

  // upper half of a word, optionally rounded and clamped
  function automatic logic [HW-1:0] reduce_hi(
    input logic [GW-1:0] w,
    input logic rnd,
    input logic sat
  );
    logic [GW:0] t;
    t = {w[GW-1], w} + (rnd ? `SFPL_PREC_HALF : '0);
    // only a positive word can round past the top
    if (sat && (t[GW] != t[GW-1])) begin
      return `SFPL_HW_SMAX;
    end
    return t[GW-1 -: HW];
  endfunction : reduce_hi

  // ****************************************************************
  // lanes: one loop, every lane size built in parallel
  // ****************************************************************
  // all three widths run every cycle; area traded for a flat mux
  genvar g;
  generate
    for (g = 0; g < N_BYTE; g++) begin : g_lane
      // byte lanes, same position in sources and result
      sfpl_lane #(.W(BW)) u_byte (
        .op_i(op_i),
        .mod_i(mod_i),
        .uns_i(lane_uns),
        .a_i(src_a_i[g*BW +: BW]),
        .b_i(src_b_i[g*BW +: BW]),
        .c_i(acc_i[g*BW +: BW]),
        .y_o(byte_res[g*BW +: BW])
      );
      // memory element g lands g bytes below the top for big-endian
      assign load_be[REG_W-1-g*BW -: BW] = mem_i[g*BW +: BW];
      if (g < N_HALF) begin : g_half
        sfpl_lane #(.W(HW)) u_half (
          .op_i(op_i),
          .mod_i(mod_i),
          .uns_i(lane_uns),
          .a_i(src_a_i[g*HW +: HW]),
          .b_i(src_b_i[g*HW +: HW]),
          .c_i(acc_i[g*HW +: HW]),
          .y_o(half_res[g*HW +: HW])
        );
      end
      if (g < N_WORD) begin : g_word
        sfpl_lane #(.W(GW)) u_word (
          .op_i(op_i),
          .mod_i(mod_i),
          .uns_i(lane_uns),
          .a_i(src_a_i[g*GW +: GW]),
          .b_i(src_b_i[g*GW +: GW]),
          .c_i(acc_i[g*GW +: GW]),
          .y_o(word_res[g*GW +: GW])
        );
        // first source fills the left half, regardless of endianness
        assign prec_res[g*GW +: GW] = {
          reduce_hi(src_a_i[g*GW +: GW], prec_rnd, prec_sat),
          reduce_hi(src_b_i[g*GW +: GW], prec_rnd, prec_sat)
        };
      end
    end
  endgenerate

  // ****************************************************************
  // result select
  // ****************************************************************
  // result holds when nothing issues, so writeback sees a stable word
  always_comb begin
    next_valid = valid_i;
    next_result = result_o;
    if (valid_i) begin
      case (op_i)
        sfpl_pkg::sfpl_op_load: begin
          next_result = big_endian_i ? load_be : mem_i;
        end
        sfpl_pkg::sfpl_op_prec: begin
          next_result = prec_res;
        end
        default: begin
          case (fmt_i)
            sfpl_pkg::halfword_pair_format: next_result = half_res;
            sfpl_pkg::byte_quad_format: next_result = byte_res;
            default: next_result = word_res;
          endcase
        end
      endcase
      // compact build keeps 32 bits and copies the sign upward
      if (compact_i) begin
        next_result = {{(REG_W-GW){next_result[`SFPL_SIGN_BIT]}},
                       next_result[GW-1:0]};
      end
    end
  end

  // output stage, outputs straight from flops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      valid_o <= 1'b0;
      result_o <= `SFPL_RST_RESULT;
    end else begin
      valid_o <= next_valid;
      result_o <= next_result;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [REG_W-1:0] prev_a; // sources of the last cycle
  logic [REG_W-1:0] prev_b;
  logic [REG_W-1:0] prev_mem;

  // operand history for the checks only
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_a <= '0;
      prev_b <= '0;
      prev_mem <= '0;
    end else begin
      prev_a <= src_a_i;
      prev_b <= src_b_i;
      prev_mem <= mem_i;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_frac_signed: assert property (
    valid_i && op_i == sfpl_pkg::sfpl_op_mulq && !compact_i &&
    mod_i == sfpl_pkg::sfpl_mod_none &&
    fmt_i == sfpl_pkg::halfword_pair_format &&
    src_a_i[31:16] == 16'hc000 && src_b_i[31:16] == 16'h4000
    |=> result_o[31:16] == 16'he000)
    else $error("fractional multiply not signed");

  a_add_any_data: assert property (
    valid_i && op_i == sfpl_pkg::sfpl_op_add && !compact_i &&
    mod_i == sfpl_pkg::sfpl_mod_none && fmt_i == sfpl_pkg::sfpl_fmt_word
    |=> valid_o && result_o[31:0] == prev_a[31:0] + prev_b[31:0])
    else $error("plain word add wrong");

  a_uns_clamp_hi: assert property (
    valid_i && op_i == sfpl_pkg::sfpl_op_add && uns_i && !compact_i &&
    mod_i == sfpl_pkg::sfpl_mod_clamp &&
    fmt_i == sfpl_pkg::byte_quad_format &&
    (9'(src_a_i[7:0]) + 9'(src_b_i[7:0])) > 9'h0ff
    |=> result_o[7:0] == 8'hff)
    else $error("unsigned overflow not clamped");

  a_uns_clamp_lo: assert property (
    valid_i && op_i == sfpl_pkg::sfpl_op_sub && uns_i && !compact_i &&
    mod_i == sfpl_pkg::sfpl_mod_clamp &&
    fmt_i == sfpl_pkg::byte_quad_format &&
    src_a_i[15:8] < src_b_i[15:8]
    |=> result_o[15:8] == 8'h00)
    else $error("unsigned underflow not clamped to zero");

  a_sgn_clamp_lo: assert property (
    valid_i && op_i == sfpl_pkg::sfpl_op_sub && !uns_i && !compact_i &&
    mod_i == sfpl_pkg::sfpl_mod_clamp &&
    fmt_i == sfpl_pkg::halfword_pair_format &&
    src_a_i[15:0] == 16'h8000 && src_b_i[15:0] == 16'h0001
    |=> result_o[15:0] == 16'h8000)
    else $error("signed underflow not clamped");

  a_round_half: assert property (
    valid_i && op_i == sfpl_pkg::sfpl_op_mulq && !compact_i &&
    fmt_i == sfpl_pkg::halfword_pair_format &&
    src_a_i[47:32] == 16'h4000 && src_b_i[47:32] == 16'h0001
    |=> result_o[47:32] ==
        (($past(mod_i) == sfpl_pkg::sfpl_mod_round ||
          $past(mod_i) == sfpl_pkg::round_and_clamp_modifier) ?
         16'h0001 : 16'h0000))
    else $error("rounding modifier misapplied");

  a_minus_one_sq: assert property (
    valid_i && op_i == sfpl_pkg::sfpl_op_mulq && !compact_i &&
    mod_i == sfpl_pkg::round_and_clamp_modifier &&
    fmt_i == sfpl_pkg::halfword_pair_format &&
    src_a_i[63:48] == 16'h8000 && src_b_i[63:48] == 16'h8000
    |=> result_o[63:48] == 16'h7fff)
    else $error("minus one squared not clamped");

  a_acc_clamp: assert property (
    valid_i && op_i == sfpl_pkg::sfpl_op_macq && !compact_i &&
    mod_i == sfpl_pkg::accumulator_clamp_modifier &&
    fmt_i == sfpl_pkg::halfword_pair_format && acc_i[63:48] == 16'h7fff &&
    src_a_i[63:48] == 16'h4000 && src_b_i[63:48] == 16'h4000
    |=> result_o[63:48] == 16'h7fff)
    else $error("accumulated sum not clamped");

  a_top_byte_lane: assert property (
    valid_i && op_i == sfpl_pkg::sfpl_op_add && !compact_i &&
    mod_i == sfpl_pkg::sfpl_mod_none &&
    fmt_i == sfpl_pkg::byte_quad_format
    |=> result_o[63:56] == 8'(prev_a[63:56] + prev_b[63:56]))
    else $error("top byte lane wrong");

  a_compact_ext: assert property (
    valid_i && compact_i
    |=> result_o[63:32] == {32{result_o[31]}})
    else $error("compact result not sign extended");

  a_load_big: assert property (
    valid_i && op_i == sfpl_pkg::sfpl_op_load && big_endian_i && !compact_i
    |=> result_o[63:56] == prev_mem[7:0] && result_o[7:0] == prev_mem[63:56])
    else $error("big-endian load order wrong");

  a_load_little: assert property (
    valid_i && op_i == sfpl_pkg::sfpl_op_load && !big_endian_i && !compact_i
    |=> result_o == prev_mem)
    else $error("little-endian load order wrong");

  a_prec_left: assert property (
    valid_i && op_i == sfpl_pkg::sfpl_op_prec && !compact_i &&
    mod_i == sfpl_pkg::sfpl_mod_none
    |=> result_o[31:16] == prev_a[31:16] && result_o[15:0] == prev_b[31:16])
    else $error("precision reduce lane placement wrong");

  // without a clamp modifier minus one squared wraps to the minimum
  a_mulq_wrap: assert property (
    valid_i && op_i == sfpl_pkg::sfpl_op_mulq && !compact_i &&
    mod_i == sfpl_pkg::sfpl_mod_none &&
    fmt_i == sfpl_pkg::halfword_pair_format &&
    src_a_i[63:48] == 16'h8000 && src_b_i[63:48] == 16'h8000
    |=> result_o[63:48] == 16'h8000)
    else $error("unclamped minus one squared not wrapped");

  // integer product keeps only the low lane bits
  a_muli_low: assert property (
    valid_i && op_i == sfpl_pkg::sfpl_op_muli && !compact_i &&
    fmt_i == sfpl_pkg::byte_quad_format
    |=> result_o[7:0] == 8'(prev_a[7:0] * prev_b[7:0]))
    else $error("integer multiply lane width wrong");
endmodule : sfpl_datapath
`default_nettype wire

//--- src/sfpl_consts.svh
// Purpose: named widths, positions and fixed values of the lane datapath
// Assumes: included by bare name from every design file that needs it
// Notes: definitions only
`ifndef SFPL_CONSTS_SVH
`define SFPL_CONSTS_SVH
// ****************************************************************
// lane geometry
// ****************************************************************
`define SFPL_REG_W 64
`define SFPL_GRP_W 32
`define SFPL_HW_W 16
`define SFPL_BYTE_W 8
// ****************************************************************
// fixed positions and values
// ****************************************************************
`define SFPL_SIGN_BIT 31
`define SFPL_PREC_HALF 33'h000008000
`define SFPL_HW_SMAX 16'h7fff
`define SFPL_RST_RESULT 64'h0
`endif

//--- src/sfpl_pkg.sv
// Purpose: shared types of the fixed-point lane datapath
// Assumes: decoder drives these encodings
// Notes: no constants here, see sfpl_consts.svh
package sfpl_pkg;
  // decoded operation class
  typedef enum logic [2:0] {
    sfpl_op_add = 3'h0,
    sfpl_op_sub = 3'h1,
    sfpl_op_macq = 3'h2,
    sfpl_op_mulq = 3'h3,
    sfpl_op_load = 3'h5,
    sfpl_op_muli = 3'h6,
    sfpl_op_prec = 3'h7
  } sfpl_op_t;
  // lane format
  typedef enum logic [1:0] {
    sfpl_fmt_word = 2'h0,
    halfword_pair_format = 2'h1,
    byte_quad_format = 2'h2
  } sfpl_fmt_t;
  // rounding / saturation modifier
  typedef enum logic [2:0] {
    sfpl_mod_none = 3'h0,
    sfpl_mod_round = 3'h1,
    sfpl_mod_clamp = 3'h2,
    round_and_clamp_modifier = 3'h3,
    accumulator_clamp_modifier = 3'h4
  } sfpl_mod_t;
endpackage : sfpl_pkg

//--- src/sfpl_lane.sv
// Purpose: one arithmetic lane of width W, purely combinational
// Assumes: fractional ops arrive with uns_i already forced low
// Notes: non-expanded results only
`timescale 1ns/10ps
`default_nettype none
`include "sfpl_consts.svh"
module sfpl_lane #(
  parameter int W = `SFPL_BYTE_W // lane width in bits
) (
  input wire sfpl_pkg::sfpl_op_t op_i,
  input wire sfpl_pkg::sfpl_mod_t mod_i,
  input wire logic uns_i,
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  input wire logic [W-1:0] c_i,
  output logic [W-1:0] y_o
);
  // ****************************************************************
  // lane bounds
  // ****************************************************************
  localparam logic [W-1:0] SMAX = {1'b0, {(W-1){1'b1}}};
  localparam logic [W-1:0] SMIN = {1'b1, {(W-1){1'b0}}};
  localparam logic [2*W-1:0] HALF = {{W{1'b0}}, SMIN}; // half of kept lsb
  localparam logic signed [W+1:0] ONE = {{(W+1){1'b0}}, 1'b1};

  logic rnd; // rounding requested
  logic sat; // per-result clamp requested
  logic minmin; // both multiplicands are -1.0
  logic signed [W+1:0] ea; // extended operands
  logic signed [W+1:0] eb;
  logic signed [W+1:0] ec;
  logic signed [W+1:0] s; // exact sum, two guard bits
  logic signed [W+1:0] hs; // rounded halving sum
  logic signed [2*W-1:0] prod; // full product
  logic [2*W-1:0] frac; // doubled product, q format
  logic [W-1:0] mres; // fractional product lane value
  logic over; // above upper bound
  logic under; // below lower bound

  // ****************************************************************
  // lane arithmetic
  // ****************************************************************
  always_comb begin
    rnd = (mod_i == sfpl_pkg::sfpl_mod_round) ||
          (mod_i == sfpl_pkg::round_and_clamp_modifier);
    sat = (mod_i == sfpl_pkg::sfpl_mod_clamp) ||
          (mod_i == sfpl_pkg::round_and_clamp_modifier) ||
          (mod_i == sfpl_pkg::accumulator_clamp_modifier);
    // unsigned only widens differently, the binary sum is the same
    ea = uns_i ? signed'({2'b00, a_i}) : signed'({{2{a_i[W-1]}}, a_i});
    eb = uns_i ? signed'({2'b00, b_i}) : signed'({{2{b_i[W-1]}}, b_i});
    ec = signed'({{2{c_i[W-1]}}, c_i});
    prod = signed'(a_i) * signed'(b_i);
    // doubling drops the redundant sign bit of a q-format product
    frac = {prod[2*W-2:0], 1'b0} + (rnd ? HALF : '0);
    minmin = (a_i == SMIN) && (b_i == SMIN);
    mres = (sat && minmin) ? SMAX : frac[2*W-1:W];
    case (op_i)
      sfpl_pkg::sfpl_op_sub: s = ea - eb;
      sfpl_pkg::sfpl_op_macq: s = ec + signed'({{2{mres[W-1]}}, mres});
      default: s = ea + eb;
    endcase
    hs = s + ONE;
    // bounds differ by signedness, nothing traps
    if (uns_i) begin
      over = !s[W+1] && s[W];
      under = s[W+1];
    end else begin
      over = !s[W+1] && (s[W] || s[W-1]);
      under = s[W+1] && !(s[W] && s[W-1]);
    end
    case (op_i)
      sfpl_pkg::sfpl_op_mulq: y_o = mres;
      sfpl_pkg::sfpl_op_muli: y_o = prod[W-1:0];
      sfpl_pkg::sfpl_op_macq: begin
        y_o = s[W-1:0];
        if (mod_i == sfpl_pkg::accumulator_clamp_modifier) begin
          if (over) begin
            y_o = SMAX;
          end else if (under) begin
            y_o = SMIN;
          end
        end
      end
      default: begin
        y_o = s[W-1:0];
        if (rnd) begin // rounded halving add, always fits
          y_o = hs[W:1];
        end else if (sat && over) begin
          y_o = uns_i ? {W{1'b1}} : SMAX;
        end else if (sat && under) begin
          y_o = uns_i ? {W{1'b0}} : SMIN;
        end
      end
    endcase
  end
endmodule : sfpl_lane
`default_nettype wire

//--- bench/sfpl_decode_model.sv
// Purpose: decode and register file stand-in that issues lane operations
// Assumes: one operation at a time, launched just after a rising edge
// Notes: released operand lines carry inverted data, never the last value
`timescale 1ns/10ps
`default_nettype none
module sfpl_decode_model (
  input wire logic clk_i,
  input wire logic valid_i, // writeback strobe from the datapath
  input wire logic [63:0] result_i, // writeback data
  output var logic valid_o,
  output var sfpl_pkg::sfpl_op_t op_o,
  output var sfpl_pkg::sfpl_fmt_t fmt_o,
  output var sfpl_pkg::sfpl_mod_t mod_o,
  output var logic uns_o,
  output var logic compact_o,
  output var logic big_endian_o,
  output var logic [63:0] src_a_o,
  output var logic [63:0] src_b_o,
  output var logic [63:0] acc_o,
  output var logic [63:0] mem_o
);
  // ****************************************************************
  // operand drive
  // ****************************************************************
  // idle values at time zero, nothing issued yet
  initial begin
    valid_o = 1'b0;
    op_o = sfpl_pkg::sfpl_op_add;
    fmt_o = sfpl_pkg::sfpl_fmt_word;
    mod_o = sfpl_pkg::sfpl_mod_none;
    {uns_o, compact_o, big_endian_o} = 3'h0;
    {src_a_o, src_b_o, acc_o, mem_o} = 256'h0;
  end
  // one issue, then two idle cycles; returns answer and the held value
  task automatic issue(input logic [2:0] op, input logic [1:0] fm,
      input logic [2:0] md, input logic [2:0] fl, input logic [63:0] a,
      input logic [63:0] b, input logic [63:0] c, output logic [63:0] r,
      output logic v, output logic [63:0] r2, output logic v2);
    @(posedge clk_i);
    valid_o <= 1'b1;
    op_o <= sfpl_pkg::sfpl_op_t'(op);
    fmt_o <= sfpl_pkg::sfpl_fmt_t'(fm);
    mod_o <= sfpl_pkg::sfpl_mod_t'(md);
    {uns_o, compact_o, big_endian_o} <= fl;
    {src_a_o, src_b_o, acc_o, mem_o} <= {a, b, c, c};
    @(posedge clk_i);
    // flipped lines so a stale sample of the operands cannot pass
    valid_o <= 1'b0;
    {src_a_o, src_b_o, acc_o, mem_o} <= ~{a, b, c, c};
    @(negedge clk_i);
    r = result_i;
    v = valid_i;
    @(negedge clk_i);
    r2 = result_i;
    v2 = valid_i;
  endtask : issue
endmodule : sfpl_decode_model
`default_nettype wire

//--- bench/sfpl_datapath_tb.sv
// Purpose: self-checking bench for the lane datapath
// Assumes: 100 MHz clock, asynchronous active-low reset
// Notes: expected lanes are worked out by hand from the lane arithmetic
`timescale 1ns/10ps
`default_nettype none
module sfpl_datapath_tb;
  // ****************************************************************
  // clock, reset and wiring
  // ****************************************************************
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0; // low from time zero
  logic valid_i, uns_i, compact_i, big_endian_i, valid_o;
  sfpl_pkg::sfpl_op_t op_i;
  sfpl_pkg::sfpl_fmt_t fmt_i;
  sfpl_pkg::sfpl_mod_t mod_i;
  logic [63:0] src_a_i, src_b_i, acc_i, mem_i, result_o;
  int failures = 0; // mismatches so far
  int n_compared = 0; // comparisons so far
  localparam int WD_CYCLES = 3000; // roughly twenty times the planned run
  always #5 clk_i = ~clk_i;
  sfpl_datapath u_dut (.clk_i, .resetn_i, .valid_i, .op_i, .fmt_i, .mod_i,
    .uns_i, .compact_i, .big_endian_i, .src_a_i, .src_b_i, .acc_i,
    .mem_i, .valid_o, .result_o);
  // decode side owns every operand input
  sfpl_decode_model u_dec (.clk_i(clk_i), .valid_i(valid_o),
    .result_i(result_o), .valid_o(valid_i), .op_o(op_i), .fmt_o(fmt_i),
    .mod_o(mod_i), .uns_o(uns_i), .compact_o(compact_i),
    .big_endian_o(big_endian_i), .src_a_o(src_a_i), .src_b_o(src_b_i),
    .acc_o(acc_i), .mem_o(mem_i));
  // ****************************************************************
  // shared checking
  // ****************************************************************
  task automatic check(input string w, input logic [63:0] s,
      input logic [63:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", w, e, s);
    end
  endtask : check
  // one operation: answer one cycle later, then held while idle
  task automatic run(input string w, input logic [2:0] op,
      input logic [1:0] fm, input logic [2:0] md, input logic [2:0] fl,
      input logic [63:0] a, input logic [63:0] b, input logic [63:0] c,
      input logic [63:0] e);
    logic [63:0] r, r2;
    logic v, v2;
    u_dec.issue(op, fm, md, fl, a, b, c, r, v, r2, v2);
    check({w, " valid"}, {63'h0, v}, 64'h1);
    check(w, r, e);
    check({w, " hold"}, r2, e);
    check({w, " idle"}, {63'h0, v2}, 64'h0);
  endtask : run
  // ****************************************************************
  // scenarios
  // ****************************************************************
  // asynchronous clear applied after a rising edge, seen at the falling edge before the next rising edge
  task automatic t_reset();
    @(posedge clk_i);
    resetn_i <= 1'b0;
    @(negedge clk_i);
    check("reset result", result_o, 64'h0);
    check("reset valid", {63'h0, valid_o}, 64'h0);
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    $display("test reset done");
  endtask : t_reset
  // wrap, signed and unsigned clamps, halving round
  task automatic t_add();
    run("add w", 3'h0, 2'h0, 3'h0, 3'h0, 64'h7fffffff_00000001,
      64'h00000001_00000002, 64'h0, 64'h80000000_00000003);
    run("add w s", 3'h0, 2'h0, 3'h2, 3'h0, 64'h7fffffff_00000001,
      64'h00000001_00000002, 64'h0, 64'h7fffffff_00000003);
    run("add w u", 3'h0, 2'h0, 3'h2, 3'h4, 64'hffffffff_00000001,
      64'h00000001_00000002, 64'h0, 64'hffffffff_00000003);
    run("add b u", 3'h0, 2'h2, 3'h2, 3'h4, 64'h80ff0001_7f0110f0,
      64'h80020001_81ff1020, 64'h0, 64'hffff0002_ffff20ff);
    run("add b", 3'h0, 2'h2, 3'h0, 3'h0, 64'h80ff7f01_01020304,
      64'h80017f01_fffefdfc, 64'h0, 64'h0000fe02_00000000);
    run("sub h s", 3'h1, 2'h1, 3'h2, 3'h0, 64'h7fff0005_00038000,
      64'hffff0007_00040001, 64'h0, 64'h7ffffffe_ffff8000);
    run("sub b u", 3'h1, 2'h2, 3'h2, 3'h4, 64'h058000ff_10203040,
      64'h06010001_0f203100, 64'h0, 64'h007f00fe_01000040);
    run("sub b s", 3'h1, 2'h2, 3'h2, 3'h0, 64'h058000ff_10203040,
      64'h06010001_0f203100, 64'h0, 64'hff8000fe_0100ff40);
    run("add h r", 3'h0, 2'h1, 3'h1, 3'h0, 64'h00030001_7fff8000,
      64'h00000000_7fff8000, 64'h0, 64'h00020001_7fff8000);
    run("add b rc", 3'h0, 2'h2, 3'h3, 3'h0, 64'h7f800100_00000000,
      64'h7f800300_00000000, 64'h0, 64'h7f800200_00000000);
    $display("test add done");
  endtask : t_add
  // fraction multiply, every modifier but accumulator clamp, all lane widths
  task automatic t_mulq();
    run("mulq h", 3'h3, 2'h1, 3'h0, 3'h0, 64'h80004000_c000ffff,
      64'h80000001_40000001, 64'h0, 64'h80000000_e000ffff);
    run("mulq h r", 3'h3, 2'h1, 3'h1, 3'h0, 64'h80004000_c000ffff,
      64'h80000001_40000001, 64'h0, 64'h80000001_e0000000);
    run("mulq h c", 3'h3, 2'h1, 3'h2, 3'h0, 64'h80004000_c000ffff,
      64'h80000001_40000001, 64'h0, 64'h7fff0000_e000ffff);
    // unsigned flag must not change a fractional multiply
    run("mulq h rc", 3'h3, 2'h1, 3'h3, 3'h4, 64'h80004000_c000ffff,
      64'h80000001_40000001, 64'h0, 64'h7fff0001_e0000000);
    run("mulq b c", 3'h3, 2'h2, 3'h2, 3'h0, 64'h80808080_80808080,
      64'h80808080_80808080, 64'h0, 64'h7f7f7f7f_7f7f7f7f);
    run("mulq w c", 3'h3, 2'h0, 3'h2, 3'h0, 64'h80000000_40000000,
      64'h80000000_00000002, 64'h0, 64'h7fffffff_00000001);
    $display("test mulq done");
  endtask : t_mulq
  // product clamp alone versus clamp of the sum as well
  task automatic t_macq();
    run("macq sa", 3'h2, 2'h1, 3'h4, 3'h0, 64'h40008000_40004000,
      64'h40008000_c0000002, 64'h7fff0000_80000010,
      64'h7fff7fff_80000011);
    run("macq", 3'h2, 2'h1, 3'h0, 3'h0, 64'h40008000_40004000,
      64'h40008000_c0000002, 64'h7fff0000_80000010,
      64'h9fff8000_60000011);
    run("macq c", 3'h2, 2'h1, 3'h2, 3'h0, 64'h40008000_40004000,
      64'h40008000_c0000002, 64'h7fff0000_80000010,
      64'h9fff7fff_60000011);
    $display("test macq done");
  endtask : t_macq
  // eight byte lanes, integer product, reduction, load order, compact
  task automatic t_misc();
    run("muli b", 3'h6, 2'h2, 3'h0, 3'h0, 64'h01020304_050610ff,
      64'h02030405_06071002, 64'h0, 64'h02060c14_1e2a00fe);
    // big-endian set: left and right halves must not move
    run("prec", 3'h7, 2'h1, 3'h0, 3'h1, 64'h12348000_7fff8000,
      64'habcd7fff_00010000, 64'h0, 64'h1234abcd_7fff0001);
    run("prec r", 3'h7, 2'h1, 3'h1, 3'h0, 64'h12348000_7fff8000,
      64'habcd7fff_00010000, 64'h0, 64'h1235abcd_80000001);
    run("prec rc", 3'h7, 2'h1, 3'h3, 3'h0, 64'h12348000_7fff8000,
      64'habcd7fff_00010000, 64'h0, 64'h1235abcd_7fff0001);
    run("load be", 3'h5, 2'h0, 3'h0, 3'h1, 64'h0, 64'h0,
      64'h08070605_04030201, 64'h01020304_05060708);
    run("load le", 3'h5, 2'h0, 3'h0, 3'h0, 64'h0, 64'h0,
      64'h08070605_04030201, 64'h08070605_04030201);
    run("cmp neg", 3'h0, 2'h0, 3'h0, 3'h2, 64'h12345678_80000000,
      64'h00000000_00000001, 64'h0, 64'hffffffff_80000001);
    run("cmp pos", 3'h0, 2'h0, 3'h0, 3'h2, 64'hffffffff_00000005,
      64'h00000000_00000001, 64'h0, 64'h00000000_00000006);
    $display("test misc done");
  endtask : t_misc
  // ****************************************************************
  // sequence and verdict
  // ****************************************************************
  task automatic wrap_up();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  // main sequence; a second reset in mid-run, then recovery
  initial begin
    t_reset();
    t_add();
    t_mulq();
    t_macq();
    t_misc();
    t_reset();
    t_add();
    wrap_up();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (WD_CYCLES) @(posedge clk_i);
    failures++;
    wrap_up();
  end
endmodule : sfpl_datapath_tb
`default_nettype wire
